// ==== cmpt_defines.vh ====
// constants for the core memory local pattern test logic
`ifndef CMPT_DEFINES_VH
`define CMPT_DEFINES_VH

`define CMPT_ADDR_W      12
`define CMPT_HALF_W      6
`define CMPT_DATA_W      48
`define CMPT_GROUPS      6
`define CMPT_CHK_X_BIT   1
`define CMPT_CHK_Y_BIT   7
`define CMPT_SW_W        19

// switch bundle positions
`define CMPT_SW_REMOTE   0
`define CMPT_SW_WORST    1
`define CMPT_SW_CHECKER  2
`define CMPT_SW_MANUAL   3
`define CMPT_SW_SINGLE   4
`define CMPT_SW_CNT_X    5
`define CMPT_SW_CNT_Y    6
`define CMPT_SW_CNT_MAR  7
`define CMPT_SW_SFA      8
`define CMPT_SW_SOE      9
`define CMPT_SW_WORD     10
`define CMPT_SW_MWRITE   11
`define CMPT_SW_START    12
`define CMPT_SW_BITS     13

// sequencer states and phases
`define CMPT_ST_IDLE     2'h0
`define CMPT_ST_ISSUE    2'h1
`define CMPT_ST_WAIT     2'h2
`define CMPT_PH_LAST_N   2'h1
`define CMPT_PH_LAST_W   2'h3
`define CMPT_PH_ZERO     2'h0
`define CMPT_PAR_ODD     1'h1

`endif

// ==== cmpt_sync2.v ====
// two-flop synchroniser for asynchronous panel levels
`timescale 1ns/1ps
module cmpt_sync2 #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             sys_clk,
	input  wire             arst_n,
	// levels
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ==== cmpt_local_test.v ====
// local maintenance pattern test logic for one core memory module
`timescale 1ns/1ps
`include "cmpt_defines.vh"

// Function
// - checkerboard switch asserts checker select level for true or inverted checkerboard.
// - manual and automatic levels are false in remote or checkerboard.
// - manual writes the information register word with generated parity.
// - manual reads check parity of each retrieved word, not a pattern.
// - automatic writes switch pattern or its inverse, no parity generated.
// - automatic reads compare against switch pattern or inverse, parity unchecked.
// - single cycle mode takes one memory cycle per start press; false in remote.
// - continuous mode keeps cycling back to back after start press.
// - low half count enabled increments lower six address bits, else holds.
// - high enabled alone counts upper six; both enabled count whole address.
// - high inhibited holds upper six; lower six wrap to zero.
// - master count inhibit suppresses every address increment.
// - halt at final address, after last write in checkerboard or automatic.
// - halt on fault drops continue on error; otherwise errors never stop.
// - halt on fault inhibits information register clear and address counting.
// - word invert selects true or inverted pattern for writing and checking.
// - each bit invert switch inverts its group, combined with word invert.
// - checkerboard bit is address bit 1 xor address bit 7.
// - bit groups are planes spaced six apart; group zero includes parity.
// - normal pattern control uses read then write per address.
// - pattern test cycles run only in local operation.
// - remote disables pattern control, checkerboard and manual selector outputs.
// - worst case pattern control uses four cycles per address.
// - two cycle sequence counts address only after the write cycle.
module cmpt_local_test (
	// clock and reset
	input  wire                     sys_clk,
	input  wire                     arst_n,
	// maintenance panel switches and start pushbutton (asynchronous)
	input  wire                     remote_sw,
	input  wire                     worst_case_sw,
	input  wire                     checker_sw,
	input  wire                     manual_sw,
	input  wire                     single_cycle_sw,
	input  wire                     low_half_count_sw,
	input  wire                     high_half_count_sw,
	input  wire                     address_count_sw,
	input  wire                     halt_at_last_address_sw,
	input  wire                     halt_on_fault_sw,
	input  wire                     word_true_sw,
	input  wire                     manual_write_sw,
	input  wire                     start_button,
	input  wire [`CMPT_GROUPS-1:0]  bit_true_sw,
	// manual load of the information register
	input  wire                     manual_load,
	input  wire [`CMPT_DATA_W-1:0]  manual_data,
	// memory cycle timing
	output reg                      mem_start,
	output reg                      mem_write,
	output reg  [`CMPT_DATA_W:0]    mem_wdata,
	input  wire                     mem_done,
	input  wire [`CMPT_DATA_W:0]    mem_rdata,
	// decoded panel levels
	output reg                      system_operation_level,
	output reg                      checker_select_level,
	output reg                      manual_pattern_level,
	output reg                      manual_switch_n,
	output reg                      auto_pattern_level,
	output reg                      one_shot_cycle_level,
	output reg                      worst_case_pattern_level,
	output reg                      normal_pattern_level,
	output reg                      continue_level,
	// status
	output reg                      running,
	output reg                      mem_error,
	output reg  [`CMPT_ADDR_W-1:0]  address_register,
	output reg  [`CMPT_DATA_W-1:0]  information_register,
	output reg  [1:0]               phase
);
	localparam HW = `CMPT_HALF_W;
	localparam DW = `CMPT_DATA_W;

	wire [`CMPT_SW_W-1:0] sw_raw;
	wire [`CMPT_SW_W-1:0] sw;
	reg  [1:0]            state;
	reg                   start_prev;
	reg  [DW:0]           expected;
	reg                   pattern_base;
	reg  [1:0]            last_phase;
	reg                   is_write;
	reg                   complement_phase;
	reg                   read_fault;
	reg                   addr_final;
	reg                   count_now;
	reg  [`CMPT_ADDR_W-1:0] next_address;
	reg                   next_checker;
	reg                   next_manual;
	reg                   next_auto;
	integer               i;

	// order follows the bit positions of the switch bundle
	assign sw_raw = {
		bit_true_sw,
		start_button,
		manual_write_sw,
		word_true_sw,
		halt_on_fault_sw,
		halt_at_last_address_sw,
		address_count_sw,
		high_half_count_sw,
		low_half_count_sw,
		single_cycle_sw,
		manual_sw,
		checker_sw,
		worst_case_sw,
		remote_sw
	};

	cmpt_sync2 #(
		.WIDTH(`CMPT_SW_W)
	) u_sync (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.async_in(sw_raw),
		.sync_out(sw)
	);

	// panel levels after the synchroniser
	wire local_op    = ~sw[`CMPT_SW_REMOTE];
	wire start_press = sw[`CMPT_SW_START] & ~start_prev & local_op;
	wire lo_en       = sw[`CMPT_SW_CNT_X];
	wire hi_en       = sw[`CMPT_SW_CNT_Y];
	wire soe         = sw[`CMPT_SW_SOE];
	wire sfa         = sw[`CMPT_SW_SFA];

	// pattern generation and cycle classification
	always @* begin
		if (checker_select_level)
			pattern_base = address_register[`CMPT_CHK_X_BIT]
				^ address_register[`CMPT_CHK_Y_BIT];
		else
			pattern_base = 1'b1;
		last_phase = worst_case_pattern_level ? `CMPT_PH_LAST_W
			: `CMPT_PH_LAST_N;
		// odd phases write in the pattern modes
		is_write = manual_pattern_level ? sw[`CMPT_SW_MWRITE] : phase[0];
		complement_phase = worst_case_pattern_level
			& (phase == 2'h1 || phase == 2'h2);
		// plane i belongs to group (i+1) mod 6; parity plane joins group 0
		for (i = 0; i <= DW; i = i + 1)
			expected[i] = pattern_base ^ ~sw[`CMPT_SW_WORD] ^ complement_phase
				^ ~sw[`CMPT_SW_BITS
				+ ((i == DW) ? 0 : (i + 1) % `CMPT_GROUPS)];
		// manual reads check odd parity, pattern reads compare every plane
		if (manual_pattern_level)
			read_fault = (^mem_rdata) != `CMPT_PAR_ODD;
		else
			read_fault = mem_rdata != expected;
		// final address: every counted half at all ones, never with none counted
		addr_final = (lo_en | hi_en)
			& (~lo_en | (&address_register[HW-1:0]))
			& (~hi_en | (&address_register[`CMPT_ADDR_W-1:HW]));
		count_now = sw[`CMPT_SW_CNT_MAR] & ~soe
			& (manual_pattern_level | phase == last_phase);
		// a half left out holds; a lone low half wraps within itself
		next_address = address_register;
		if (lo_en && hi_en)
			next_address = address_register + 1'b1;
		else if (lo_en)
			next_address[HW-1:0] = address_register[HW-1:0] + 1'b1;
		else if (hi_en)
			next_address[`CMPT_ADDR_W-1:HW] =
				address_register[`CMPT_ADDR_W-1:HW] + 1'b1;
	end

	wire cycle_end    = (state == `CMPT_ST_WAIT) & mem_done;
	wire new_fault    = cycle_end & ~mem_write & read_fault;
	wire last_write   = mem_write & (manual_pattern_level | phase == last_phase);
	wire final_stop   = sfa & addr_final & last_write;
	// a press in idle clears the flag, so a stale error must not hold continue low
	wire error_clear  = start_press & (state == `CMPT_ST_IDLE);
	wire fault_stop   = soe & ((mem_error & ~error_clear) | new_fault);
	// the final stop leaves the last address in the register
	wire do_count     = count_now & ~final_stop;

	// next values of the decoded selector levels
	always @* begin
		next_checker = local_op & sw[`CMPT_SW_CHECKER];
		next_manual  = local_op & ~sw[`CMPT_SW_CHECKER] & sw[`CMPT_SW_MANUAL];
		next_auto    = local_op & ~sw[`CMPT_SW_CHECKER] & ~sw[`CMPT_SW_MANUAL];
	end

	// decoded panel levels
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			system_operation_level   <= 1'b0;
			checker_select_level     <= 1'b0;
			manual_pattern_level     <= 1'b0;
			manual_switch_n          <= 1'b1;
			auto_pattern_level       <= 1'b0;
			one_shot_cycle_level     <= 1'b0;
			worst_case_pattern_level <= 1'b0;
			normal_pattern_level     <= 1'b0;
			start_prev               <= 1'b0;
		end else begin
			system_operation_level   <= sw[`CMPT_SW_REMOTE];
			checker_select_level     <= next_checker;
			manual_pattern_level     <= next_manual;
			manual_switch_n          <= ~next_manual;
			auto_pattern_level       <= next_auto;
			one_shot_cycle_level     <= local_op & sw[`CMPT_SW_SINGLE];
			worst_case_pattern_level <= local_op & sw[`CMPT_SW_WORST];
			normal_pattern_level     <= local_op & ~sw[`CMPT_SW_WORST];
			start_prev               <= sw[`CMPT_SW_START];
		end
	end

	// cycle sequencer, memory cycle outputs and information register
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state                <= `CMPT_ST_IDLE;
			running              <= 1'b0;
			mem_start            <= 1'b0;
			mem_write            <= 1'b0;
			mem_wdata            <= {(DW+1){1'b0}};
			information_register <= {DW{1'b0}};
			phase                <= `CMPT_PH_ZERO;
		end else begin
			mem_start <= 1'b0;
			if (error_clear && manual_pattern_level)
				phase <= `CMPT_PH_ZERO;
			if (manual_load && state == `CMPT_ST_IDLE && manual_pattern_level)
				information_register <= manual_data;
			case (state)
			`CMPT_ST_IDLE: begin
				if (start_press) begin
					running <= 1'b1;
					state   <= `CMPT_ST_ISSUE;
				end
			end
			`CMPT_ST_ISSUE: begin
				// leaving local ends the run before another cycle
				if (!local_op) begin
					running <= 1'b0;
					state   <= `CMPT_ST_IDLE;
				end else begin
					mem_start <= 1'b1;
					mem_write <= is_write;
					if (manual_pattern_level)
						mem_wdata <= {~^information_register, information_register};
					else
						mem_wdata <= expected;
					if (is_write && !manual_pattern_level)
						information_register <= expected[DW-1:0];
					state <= `CMPT_ST_WAIT;
				end
			end
			`CMPT_ST_WAIT: begin
				if (mem_done) begin
					// manual reads clear the register unless halt on fault is selected or the word faulted
					if (!mem_write) begin
						if (manual_pattern_level && !soe && !read_fault)
							information_register <= {DW{1'b0}};
						else if (!manual_pattern_level)
							information_register <= mem_rdata[DW-1:0];
					end
					if (!manual_pattern_level)
						phase <= (phase == last_phase) ? `CMPT_PH_ZERO : phase + 2'h1;
					if (one_shot_cycle_level || fault_stop || final_stop) begin
						running <= 1'b0;
						state   <= `CMPT_ST_IDLE;
					end else begin
						state <= `CMPT_ST_ISSUE;
					end
				end
			end
			default: begin
				state   <= `CMPT_ST_IDLE;
				running <= 1'b0;
			end
			endcase
		end
	end

	// address register, counted at the end of a counting cycle
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			address_register <= {`CMPT_ADDR_W{1'b0}};
		else if (cycle_end && do_count)
			address_register <= next_address;
	end

	// sticky error flag and continue level; a new fault wins over a clear
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_error      <= 1'b0;
			continue_level <= 1'b1;
		end else begin
			continue_level <= ~fault_stop;
			if (new_fault)
				mem_error <= 1'b1;
			else if (error_clear)
				mem_error <= 1'b0;
		end
	end
endmodule

// ==== cmpt_chk.sv ====
// port assertions for the local pattern test logic
`timescale 1ns/1ps
module cmpt_chk (
	// clock and reset
	input wire        sys_clk,
	input wire        arst_n,
	// memory cycle and levels
	input wire        mem_start,
	input wire        mem_write,
	input wire        mem_done,
	input wire [48:0] mem_wdata,
	input wire        system_operation_level,
	input wire        checker_select_level,
	input wire        manual_pattern_level,
	input wire        auto_pattern_level,
	input wire        one_shot_cycle_level,
	input wire        worst_case_pattern_level,
	input wire        normal_pattern_level,
	input wire        continue_level,
	input wire        running,
	input wire [11:0] address_register,
	input wire [1:0]  phase
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	remote_levels_a: assert property (system_operation_level |-> !(checker_select_level
		| manual_pattern_level | auto_pattern_level | one_shot_cycle_level
		| worst_case_pattern_level | normal_pattern_level)) else $error("level set in remote");
	checker_mode_a: assert property (checker_select_level |-> !manual_pattern_level
		&& !auto_pattern_level) else $error("selector level in checkerboard");
	manual_parity_a: assert property (mem_start && mem_write && manual_pattern_level
		|-> ^mem_wdata) else $error("manual word parity not odd");
	normal_count_a: assert property (normal_pattern_level && !manual_pattern_level
		&& address_register != $past(address_register) |-> $past(phase) == 2'h1)
		else $error("address moved before write cycle");
	worst_count_a: assert property (worst_case_pattern_level && !manual_pattern_level
		&& address_register != $past(address_register) |-> $past(phase) == 2'h3)
		else $error("address moved before fourth cycle");
	single_stop_a: assert property (one_shot_cycle_level && mem_done |=> !running)
		else $error("single cycle kept running");
	fault_halt_a: assert property (!continue_level |-> !mem_start ##1 !mem_start)
		else $error("cycle started after fault halt");
	manual_phase_a: assert property (manual_pattern_level && running |-> phase == 2'h0)
		else $error("manual run left phase zero");
	cover property (mem_start && mem_write && checker_select_level);
	cover property (!continue_level);
	cover property (mem_start && manual_pattern_level);
endmodule
bind cmpt_local_test cmpt_chk chk_u (.*);

// ==== cmpt_mem_model.sv ====
// memory timing partner: stores words, answers each cycle after a delay
`timescale 1ns/1ps
module cmpt_mem_model (
	// clock and reset
	input  wire        sys_clk,
	input  wire        arst_n,
	// cycle request
	input  wire        mem_start,
	input  wire        mem_write,
	input  wire [48:0] mem_wdata,
	input  wire [11:0] address_register,
	// bench controls
	input  wire        slow,
	input  wire        inject,
	// answer
	output reg         mem_done,
	output reg  [48:0] mem_rdata
);
	reg     [48:0] store [0:4095];
	reg     [2:0]  wait_cnt;
	reg     [11:0] addr;
	integer        i;
	initial for (i = 0; i < 4096; i = i + 1) store[i] = 49'h0;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mem_done <= 1'b0;
			wait_cnt <= 3'h0;
			mem_rdata <= 49'h0;
		end else begin
			mem_done <= wait_cnt == 3'h1;
			// read lines are not held outside the answer cycle
			mem_rdata <= ~mem_rdata;
			if (mem_start) begin
				wait_cnt <= slow ? 3'h5 : 3'h1;
				addr <= address_register;
			end else if (wait_cnt != 3'h0)
				wait_cnt <= wait_cnt - 3'h1;
			if (wait_cnt == 3'h1) begin
				mem_rdata <= store[addr] ^ {48'h0, inject};
				if (mem_write)
					store[addr] <= mem_wdata;
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the local pattern test logic
`timescale 1ns/1ps
module tb_top;
	reg          sys_clk, arst_n, manual_load, slow, inject;
	reg  [18:0]  sw;
	reg  [47:0]  manual_data;
	wire         mem_start, mem_write, mem_done, system_operation_level, checker_select_level;
	wire         manual_pattern_level, manual_switch_n, auto_pattern_level, one_shot_cycle_level;
	wire         worst_case_pattern_level, normal_pattern_level, continue_level, running, mem_error;
	wire [48:0]  mem_wdata, mem_rdata;
	wire [11:0]  address_register;
	wire [47:0]  information_register;
	wire [1:0]   phase;
	integer      bad_count, check_count, starts, cyc;
	cmpt_local_test dut_u (.remote_sw(sw[0]), .worst_case_sw(sw[1]), .checker_sw(sw[2]),
		.manual_sw(sw[3]), .single_cycle_sw(sw[4]), .low_half_count_sw(sw[5]),
		.high_half_count_sw(sw[6]), .address_count_sw(sw[7]), .halt_at_last_address_sw(sw[8]),
		.halt_on_fault_sw(sw[9]), .word_true_sw(sw[10]), .manual_write_sw(sw[11]),
		.start_button(sw[12]), .bit_true_sw(sw[18:13]), .*);
	cmpt_mem_model mem_u (.*);
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", check_count, bad_count);
			if (bad_count == 0 && check_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task cmp(input [48:0] got, input [48:0] exp, input [8*12-1:0] what);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR %0t %0s", $time, what);
			end
		end
	endtask
	function [48:0] pat(input comp);
		integer i;
		begin
			for (i = 0; i < 49; i = i + 1)
				pat[i] = (sw[2] ? address_register[1] ^ address_register[7] : 1'b1)
					^ !sw[10] ^ comp ^ !sw[13 + (i == 48 ? 0 : (i + 1) % 6)];
		end
	endfunction
	always @(negedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			print_verdict;
		end else if (mem_start === 1'b1) begin
			starts = starts + 1;
			if (mem_write && !(sw[3] && !sw[2]))
				cmp(mem_wdata, pat(sw[1] && phase == 2'h1), "pattern");
			if (mem_write && sw[3] && !sw[2])
				cmp(mem_wdata, {~^manual_data, manual_data}, "manual word");
		end
	end
	task run(input [18:0] s, input integer n, input [11:0] a);
		integer k, s0;
		begin
			@(posedge sys_clk) sw <= s;
			repeat (6) @(posedge sys_clk);
			s0 = starts;
			sw[12] <= 1'b1;
			repeat (6) @(posedge sys_clk);
			sw[12] <= 1'b0;
			repeat (6) @(posedge sys_clk);
			for (k = 0; k < 3000 && running !== 1'b0; k = k + 1)
				@(negedge sys_clk);
			cmp(running, 1'b0, "run stopped");
			cmp(starts - s0, n, "cycle count");
			cmp(address_register, a, "end address");
		end
	endtask
	initial begin
		{sw, manual_load, manual_data, slow, inject} = 0;
		{bad_count, check_count, starts, cyc} = 0;
		arst_n = 1'b0;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		run(19'h00017, 0, 12'h000);
		cmp(system_operation_level, 1'b1, "remote level");
		run(19'h7C5AC, 128, 12'h03F);
		run(19'h7C1CE, 256, 12'hFFF);
		run(19'h7E470, 1, 12'hFFF);
		run(19'h7E470, 1, 12'hFFF);
		inject <= 1'b1;
		run(19'h7E6A0, 1, 12'hFFF);
		cmp({mem_error, continue_level}, 2'b10, "fault halt");
		inject <= 1'b0;
		slow <= 1'b1;
		@(posedge sys_clk) sw <= 19'h00818;
		repeat (6) @(posedge sys_clk);
		manual_load <= 1'b1;
		manual_data <= 48'h1234_5678_9ABC;
		@(posedge sys_clk) manual_load <= 1'b0;
		run(19'h00818, 1, 12'hFFF);
		run(19'h00018, 1, 12'hFFF);
		cmp(mem_error, 1'b0, "good parity");
		inject <= 1'b1;
		run(19'h00018, 1, 12'hFFF);
		cmp(mem_error, 1'b1, "bad parity");
		print_verdict;
	end
endmodule
